// ---- aec_cmd_exec.sv ----
// task-file command executor: erase, diagnostic, flush and format track
// assumes a media engine that answers each request with one done pulse
//
// Behaviour
// RQ1 - command C0h erases and conditions the addressed sectors
// RQ2 - erase moves no data; a media fault ends it with write fault
// RQ3 - drive/head bit 6 picks LBA, bit 4 drive; cylinders give upper address
// RQ4 - sector number register gives address bits 7:0 for erase
// RQ5 - erase length comes from the sector count register
// RQ6 - command 90h runs the internal diagnostic
// RQ7 - diagnostic result code lands in the error register
// RQ8 - IDE master reports a failed slave with upper nibble 8
// RQ9 - PC card mode: only the selected drive runs the diagnostic
// RQ10 - IDE mode: both drives run it, master returns combined status
// RQ11 - E7h flushes cache, then status shows ready and seek complete
// RQ12 - flush unsupported ends with command aborted
// RQ13 - 50h fills the addressed track with a fixed pattern
// RQ14 - format takes one sector of host data and discards it
// RQ15 - LBA format length from sector count, zero meaning 256
// RQ16 - host should avoid issuing format track
// RQ17 - host writes a command only while busy is clear
// RQ18 - busy rises within 400 ns of a no-data command
// RQ19 - format raises DRQ within 700 us, busy drops with DRQ
// RQ20 - completion clears busy and raises interrupt when enabled
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module aec_cmd_exec
	import aec_pkg::*;
#(
	parameter logic [7:0] FILL_PATTERN = 8'hFF
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// register port
	input  wire logic [3:0]    busAddr,
	input  wire logic [15:0]   busWdata,
	input  wire logic          busWr,
	input  wire logic          busRd,
	output logic      [15:0]   busRdata,
	// media engine
	output aec_med_req_t       medReq,
	input  aec_med_rsp_t       medRsp,
	// drive-to-drive and host lines
	input  wire logic          slaveDiagFail,
	output logic               intrq
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_PREP  = 3'b001,
		ST_XFER  = 3'b011,
		ST_EXEC  = 3'b010,
		ST_ABORT = 3'b110
	} aec_state_t;

	typedef struct packed {
		aec_state_t   state;
		logic [7:0]   secCnt;
		logic [7:0]   secNum;
		logic [7:0]   cylLow;
		logic [7:0]   cylHigh;
		logic [7:0]   drvHead;
		logic [7:0]   cmd;
		logic [7:0]   errReg;
		logic         bsy;
		logic         drq;
		logic         dwf;
		logic         err;
		logic         nIen;
		logic [2:0]   cfg;
		logic         pend;
		logic [3:0]   prepCnt;
		logic [7:0]   wordCnt;
		aec_med_req_t req;
		logic [15:0]  rdata;
	} aec_regs_t;

	aec_regs_t q_reg;
	aec_regs_t q_next;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// zero in the count register stands for a full 256
	function automatic logic [8:0] xferCount(input logic [7:0] sc);
		xferCount = (sc == 8'h00) ? 9'h100 : {1'b0, sc};
	endfunction

	function automatic logic [27:0] startAddr(input aec_regs_t r, input logic withSector);
		startAddr = {r.drvHead[3:0], r.cylHigh, r.cylLow,
			(withSector ? r.secNum : 8'h00)};
	endfunction

	function automatic logic [7:0] statusByte(input aec_regs_t r);
		statusByte = {r.bsy, 1'b1, r.dwf, 1'b1, r.drq, 2'b00, r.err};
	endfunction

	logic selected;
	logic diagRuns;
	logic cmdWrite;

	always_comb begin
		selected = (q_reg.drvHead[DH_DRIVE_BIT] == q_reg.cfg[CFG_SLAVE_BIT]);
		diagRuns = q_reg.cfg[CFG_IDE_BIT] || selected; // RQ9 RQ10
		cmdWrite = busWr && (busAddr == OFS_CMD_STAT) && !q_reg.bsy && (q_reg.state == ST_IDLE); // RQ17
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		q_next = q_reg;
		q_next.req.valid = 1'b0;

		// reads answer one cycle later from a flop
		q_next.rdata = 16'h0000;
		if (busRd) begin
			unique case (busAddr)
				OFS_SEC_CNT:  q_next.rdata = {8'h00, q_reg.secCnt};
				OFS_SEC_NUM:  q_next.rdata = {8'h00, q_reg.secNum};
				OFS_CYL_LOW:  q_next.rdata = {8'h00, q_reg.cylLow};
				OFS_CYL_HIGH: q_next.rdata = {8'h00, q_reg.cylHigh};
				OFS_DRV_HEAD: q_next.rdata = {8'h00, q_reg.drvHead};
				OFS_CMD_STAT: begin
					q_next.rdata = {8'h00, statusByte(q_reg)};
					q_next.pend  = 1'b0;
				end
				OFS_ERROR:    q_next.rdata = {8'h00, q_reg.errReg};
				OFS_DEV_CTL:  q_next.rdata = {14'h0000, q_reg.nIen, 1'b0};
				OFS_CONFIG:   q_next.rdata = {13'h0000, q_reg.cfg};
				default:      q_next.rdata = 16'h0000;
			endcase
		end

		// task file writes are held off while busy, except device control
		if (busWr) begin
			unique case (busAddr)
				OFS_SEC_CNT:  if (!q_reg.bsy) q_next.secCnt = busWdata[7:0];
				OFS_SEC_NUM:  if (!q_reg.bsy) q_next.secNum = busWdata[7:0];
				OFS_CYL_LOW:  if (!q_reg.bsy) q_next.cylLow = busWdata[7:0];
				OFS_CYL_HIGH: if (!q_reg.bsy) q_next.cylHigh = busWdata[7:0];
				OFS_DRV_HEAD: if (!q_reg.bsy) q_next.drvHead = busWdata[7:0];
				OFS_DEV_CTL:  q_next.nIen = busWdata[CTL_NIEN_BIT];
				OFS_CONFIG:   if (!q_reg.bsy) q_next.cfg = busWdata[2:0];
				default: begin
				end
			endcase
		end

		// command decode; busy rises on the very next edge
		if (cmdWrite) begin
			q_next.cmd = busWdata[7:0];
			q_next.pend = 1'b0;
			q_next.req.lbaMode = q_reg.drvHead[DH_LBA_BIT]; // RQ3
			q_next.req.pattern = FILL_PATTERN;
			unique case (busWdata[7:0])
				CMD_ERASE: if (selected) begin
					q_next.bsy = 1'b1; // RQ18
					q_next.err = 1'b0;
					q_next.dwf = 1'b0;
					q_next.errReg = RST_ERROR;
					q_next.req.valid = 1'b1; // RQ1 RQ2
					q_next.req.op = MED_ERASE;
					q_next.req.addr = startAddr(q_reg, 1'b1); // RQ3 RQ4
					q_next.req.count = xferCount(q_reg.secCnt); // RQ5
					q_next.state = ST_EXEC;
				end
				CMD_DIAG: if (diagRuns) begin
					q_next.bsy = 1'b1; // RQ18
					q_next.err = 1'b0;
					q_next.dwf = 1'b0;
					q_next.req.valid = 1'b1; // RQ6
					q_next.req.op = MED_DIAG;
					q_next.state = ST_EXEC;
				end
				CMD_FLUSH: if (selected) begin
					q_next.bsy = 1'b1; // RQ18
					q_next.err = 1'b0;
					q_next.dwf = 1'b0;
					q_next.errReg = RST_ERROR;
					if (q_reg.cfg[CFG_FLUSH_BIT]) begin
						q_next.req.valid = 1'b1; // RQ11
						q_next.req.op = MED_FLUSH;
						q_next.state = ST_EXEC;
					end else begin
						q_next.state = ST_ABORT; // RQ12
					end
				end
				CMD_FORMAT: if (selected) begin
					q_next.bsy = 1'b1;
					q_next.err = 1'b0;
					q_next.dwf = 1'b0;
					q_next.errReg = RST_ERROR;
					q_next.prepCnt = PREP_CYC;
					q_next.state = ST_PREP;
				end
				// other codes belong to other blocks; abort them here
				default: if (selected) begin
					q_next.bsy = 1'b1;
					q_next.state = ST_ABORT;
				end
			endcase
		end

		unique case (q_reg.state)
			ST_IDLE: begin
			end
			ST_PREP: begin
				// fixed short buffer setup, far inside the DRQ limit
				if (q_reg.prepCnt == 4'h0) begin
					q_next.drq = 1'b1; // RQ19
					q_next.bsy = 1'b0; // RQ19
					q_next.wordCnt = 8'h00;
					q_next.state = ST_XFER;
				end else begin
					q_next.prepCnt = q_reg.prepCnt - 4'h1;
				end
			end
			ST_XFER: begin
				// the sector is counted, never stored
				if (busWr && (busAddr == OFS_DATA)) begin // RQ14
					q_next.wordCnt = q_reg.wordCnt + 8'h01;
					if (q_reg.wordCnt == SECTOR_WORDS_M1) begin
						q_next.drq = 1'b0;
						q_next.bsy = 1'b1;
						q_next.req.valid = 1'b1; // RQ13
						q_next.req.op = MED_FORMAT;
						q_next.req.lbaMode = q_reg.drvHead[DH_LBA_BIT];
						q_next.req.addr = startAddr(q_reg, 1'b0); // RQ3
						// chs formats the whole track, flagged by zero
						q_next.req.count = q_reg.drvHead[DH_LBA_BIT] ?
							xferCount(q_reg.secCnt) : 9'h000; // RQ15
						q_next.state = ST_EXEC;
					end
				end
			end
			ST_EXEC: begin
				if (medRsp.done) begin
					q_next.bsy = 1'b0; // RQ20
					q_next.pend = 1'b1; // RQ20
					q_next.state = ST_IDLE;
					if (q_reg.req.op == MED_DIAG) begin
						// master folds in the slave result
						if (q_reg.cfg[CFG_IDE_BIT] && !q_reg.cfg[CFG_SLAVE_BIT] && slaveDiagFail)
							q_next.errReg = {DIAG_SLAVE_NIB, medRsp.diagCode[3:0]}; // RQ8 RQ10
						else
							q_next.errReg = medRsp.diagCode; // RQ7
					end else if (medRsp.fault) begin
						q_next.dwf = 1'b1; // RQ2
						q_next.err = 1'b1;
					end
				end
			end
			ST_ABORT: begin
				q_next.errReg = RST_ERROR | (8'h01 << ERR_ABRT_BIT); // RQ12
				q_next.err = 1'b1;
				q_next.bsy = 1'b0;
				q_next.pend = 1'b1; // RQ20
				q_next.state = ST_IDLE;
			end
			default: q_next.state = ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_reg.state <= ST_IDLE;
			q_reg.secCnt <= RST_TASKFILE;
			q_reg.secNum <= RST_TASKFILE;
			q_reg.cylLow <= RST_TASKFILE;
			q_reg.cylHigh <= RST_TASKFILE;
			q_reg.drvHead <= RST_TASKFILE;
			q_reg.cmd <= RST_TASKFILE;
			q_reg.errReg <= RST_ERROR;
			q_reg.bsy <= 1'b0;
			q_reg.drq <= 1'b0;
			q_reg.dwf <= 1'b0;
			q_reg.err <= 1'b0;
			q_reg.nIen <= 1'b0;
			q_reg.cfg <= RST_CONFIG;
			q_reg.pend <= 1'b0;
			q_reg.prepCnt <= 4'h0;
			q_reg.wordCnt <= 8'h00;
			q_reg.req <= '0;
			q_reg.rdata <= 16'h0000;
		end else begin
			q_reg <= q_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_comb begin
		busRdata = q_reg.rdata;
		medReq = q_reg.req;
		intrq = q_reg.pend && !q_reg.nIen; // RQ20
	end

endmodule

// ---- aec_pkg.sv ----
// constants and carrier types of the task-file command executor
// assumes a 100 MHz core clock and a media engine behind a req/rsp pair
package aec_pkg;

	// ----------------------------------------
	// register offsets on the plain port
	// ----------------------------------------
	localparam logic [3:0] OFS_SEC_CNT  = 4'h0;
	localparam logic [3:0] OFS_SEC_NUM  = 4'h1;
	localparam logic [3:0] OFS_CYL_LOW  = 4'h2;
	localparam logic [3:0] OFS_CYL_HIGH = 4'h3;
	localparam logic [3:0] OFS_DRV_HEAD = 4'h4;
	localparam logic [3:0] OFS_CMD_STAT = 4'h5;
	localparam logic [3:0] OFS_ERROR    = 4'h6;
	localparam logic [3:0] OFS_DEV_CTL  = 4'h7;
	localparam logic [3:0] OFS_CONFIG   = 4'h8;
	localparam logic [3:0] OFS_DATA     = 4'h9;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int DH_LBA_BIT    = 6;
	localparam int DH_DRIVE_BIT  = 4;
	localparam int CTL_NIEN_BIT  = 1;
	localparam int CFG_IDE_BIT   = 0;
	localparam int CFG_SLAVE_BIT = 1;
	localparam int CFG_FLUSH_BIT = 2;
	localparam int ERR_ABRT_BIT  = 2;

	// ----------------------------------------
	// command codes and result codes
	// ----------------------------------------
	localparam logic [7:0] CMD_ERASE  = 8'hC0;
	localparam logic [7:0] CMD_DIAG   = 8'h90;
	localparam logic [7:0] CMD_FLUSH  = 8'hE7;
	localparam logic [7:0] CMD_FORMAT = 8'h50;
	localparam logic [7:0] DIAG_OK        = 8'h01;
	localparam logic [7:0] DIAG_FORMATTER = 8'h02;
	localparam logic [7:0] DIAG_BUFFER    = 8'h03;
	localparam logic [7:0] DIAG_ECC       = 8'h04;
	localparam logic [7:0] DIAG_CPU       = 8'h05;
	localparam logic [3:0] DIAG_SLAVE_NIB = 4'h8;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_TASKFILE = 8'h00;
	localparam logic [7:0] RST_ERROR    = 8'h00;
	localparam logic [2:0] RST_CONFIG   = 3'h4;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int BSY_MAX_NS     = 400;
	localparam int BSY_MAX_CYC    = BSY_MAX_NS / CLK_PERIOD_NS;
	localparam int DRQ_MAX_US     = 700;
	localparam int DRQ_MAX_CYC    = DRQ_MAX_US * 1000 / CLK_PERIOD_NS;
	localparam logic [3:0] PREP_CYC = 4'h8;
	localparam logic [7:0] SECTOR_WORDS_M1 = 8'hFF;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MED_ERASE  = 2'b00,
		MED_DIAG   = 2'b01,
		MED_FLUSH  = 2'b10,
		MED_FORMAT = 2'b11
	} aec_med_op_t;

	typedef struct packed {
		logic        valid;
		aec_med_op_t op;
		logic        lbaMode;
		logic [27:0] addr;
		logic [8:0]  count;
		logic [7:0]  pattern;
	} aec_med_req_t;

	typedef struct packed {
		logic       done;
		logic       fault;
		logic [7:0] diagCode;
	} aec_med_rsp_t;

endpackage

// ---- aec_media_model.sv ----
// stand-in for the media engine behind the command executor
// assumes one request in flight; the bench sets latency and result
`timescale 1ns/100ps
module aec_media_model
	import aec_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// request and answer
	input  aec_med_req_t    req,
	output aec_med_rsp_t    rsp,
	// behaviour chosen by the bench
	input  wire logic [3:0] lat,
	input  wire logic       fault,
	input  wire logic [7:0] code
);
	logic [3:0] cnt;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt <= 4'h0;
		else if (req.valid)
			cnt <= lat;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end

	// outside done the fields wander, so a stale sample never looks right
	assign rsp.done     = (cnt == 4'h1);
	assign rsp.fault    = rsp.done ? fault : cnt[0];
	assign rsp.diagCode = rsp.done ? code : {4'h0, cnt} ^ 8'h5A;
endmodule

// ---- aec_cmd_exec_chk.sv ----
// port assertions of the command executor
// assumes bound into the executor; one clock domain
`timescale 1ns/100ps
module aec_cmd_exec_chk
	import aec_pkg::*;
#(
	parameter logic [7:0] FILL_PATTERN = 8'hFF
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [3:0]  busAddr,
	input  wire logic [15:0] busWdata,
	input  wire logic        busWr,
	input  wire logic        busRd,
	input  wire logic [15:0] busRdata,
	// media, drive-to-drive and host lines
	input  aec_med_req_t     medReq,
	input  aec_med_rsp_t     medRsp,
	input  wire logic        slaveDiagFail,
	input  wire logic        intrq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence cmdWr(logic [7:0] c);
		busWr && busAddr == OFS_CMD_STAT && busWdata[7:0] == c;
	endsequence
	sequence reqOf(aec_med_op_t o);
		medReq.valid && medReq.op == o;
	endsequence

	erase_req_a: assert property (cmdWr(CMD_ERASE) ##1 medReq.valid |-> reqOf(MED_ERASE))
		else $error("erase gave wrong request");
	diag_req_a: assert property (cmdWr(CMD_DIAG) ##1 medReq.valid |-> reqOf(MED_DIAG))
		else $error("diagnostic gave wrong request");
	flush_req_a: assert property (cmdWr(CMD_FLUSH) ##1 medReq.valid |-> reqOf(MED_FLUSH))
		else $error("flush gave wrong request");
	req_cause_a: assert property (medReq.valid && medReq.op != MED_FORMAT |->
		$past(busWr && busAddr == OFS_CMD_STAT)) else $error("request without command");
	fmt_data_a: assert property (reqOf(MED_FORMAT) |-> $past(busWr && busAddr == OFS_DATA))
		else $error("format before data sector");
	fmt_fill_a: assert property (reqOf(MED_FORMAT) |-> medReq.pattern == FILL_PATTERN)
		else $error("format fill pattern wrong");
	count_range_a: assert property (reqOf(MED_ERASE) or (reqOf(MED_FORMAT)
		and medReq.lbaMode) |-> medReq.count inside {[9'd1:9'd256]}) else $error("bad count");
	busy_read_a: assert property (medReq.valid && busRd && busAddr == OFS_CMD_STAT
		&& !medRsp.done |=> busRdata[7]) else $error("busy missing after command");
	irq_cause_a: assert property ($rose(intrq) |-> $past(medRsp.done) || $past(busWr)
		|| $past(busWr, 2)) else $error("interrupt without completion");
endmodule

bind aec_cmd_exec aec_cmd_exec_chk #(.FILL_PATTERN(FILL_PATTERN)) u_chk (.clk(clk),
	.rst_n(rst_n), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
	.busRdata(busRdata), .medReq(medReq), .medRsp(medRsp), .slaveDiagFail(slaveDiagFail),
	.intrq(intrq));

// ---- aec_cmd_exec_bench.sv ----
// self-checking bench of the command executor
// assumes the media model answers within 9 cycles
`timescale 1ns/100ps
module aec_cmd_exec_bench
	import aec_pkg::*;
;
	logic         clk, rst_n, busWr, busRd, slaveDiagFail, fault, intrq, lba;
	logic [3:0]   busAddr, lat;
	logic [15:0]  busWdata, busRdata, rdv;
	logic [7:0]   code;
	logic [7:0]   tf[5];
	aec_med_req_t medReq, lastReq;
	aec_med_rsp_t medRsp;
	int           badCount, nTests, reqCount, cyc, n;

	aec_cmd_exec u_dut (.clk(clk), .rst_n(rst_n), .busAddr(busAddr), .busWdata(busWdata),
		.busWr(busWr), .busRd(busRd), .busRdata(busRdata), .medReq(medReq),
		.medRsp(medRsp), .slaveDiagFail(slaveDiagFail), .intrq(intrq));
	aec_media_model u_med (.clk(clk), .rst_n(rst_n), .req(medReq), .rsp(medRsp),
		.lat(lat), .fault(fault), .code(code));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (medReq.valid === 1'b1) begin
			lastReq <= medReq;
			reqCount <= reqCount + 1;
		end
		if (cyc == 6000) begin
			badCount++;
			summarize();
		end
	end

	function logic [15:0] expCnt(logic [7:0] s);
		return (s == 8'h00) ? 16'h0100 : {8'h00, s};
	endfunction

	task chk(string name, logic [15:0] got, logic [15:0] exp);
		nTests++;
		if (got !== exp) begin
			badCount++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task wr(logic [3:0] a, logic [15:0] d);
		@(posedge clk);
		busWr <= 1'b1;
		busAddr <= a;
		busWdata <= d;
		@(posedge clk);
		busWr <= 1'b0;
	endtask

	task rd(logic [3:0] a);
		@(posedge clk);
		busRd <= 1'b1;
		busAddr <= a;
		@(posedge clk);
		busRd <= 1'b0;
		#1 rdv = busRdata;
	endtask

	// busy must read clear first; status read right behind the command, no gap
	task cmd(logic [7:0] c, logic busy);
		rd(OFS_CMD_STAT);
		chk("idle before command", {15'h0, rdv[7]}, 16'h0000);
		wr(OFS_CMD_STAT, {8'h00, c});
		busRd <= 1'b1;
		busAddr <= OFS_CMD_STAT;
		@(posedge clk);
		busRd <= 1'b0;
		#1 chk("busy", {15'h0, busRdata[7]}, {15'h0, busy});
	endtask

	task fin(logic [7:0] st, logic irq);
		repeat (20) @(posedge clk);
		chk("intrq", {15'h0, intrq}, {15'h0, irq});
		rd(OFS_CMD_STAT);
		chk("status", rdv, {8'h00, st});
		chk("intrq clear", {15'h0, intrq}, 16'h0000);
	endtask

	task load(logic l, logic drv, logic f, logic [7:0] c);
		foreach (tf[i]) tf[i] = 8'($urandom);
		tf[4][7:4] = {1'b1, l, 1'b1, drv};
		for (int i = 0; i < 5; i++) wr(4'(i), {8'h00, tf[i]});
		lat <= 4'(2 + $urandom % 8);
		fault <= f;
		code <= c;
	endtask

	task summarize();
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		{busWr, busRd, slaveDiagFail, fault, rst_n} = 5'h00;
		{busAddr, lat, busWdata, code} = '0;
		{badCount, nTests, reqCount, cyc} = '0;
		void'($urandom(32'h8034_82a1));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_CMD_STAT);
		chk("reset status", rdv, 16'h0050);
		rd(OFS_ERROR);
		chk("reset error", rdv, 16'h0000);
		rd(4'hC);
		chk("unmapped", rdv, 16'h0000);
		rd(OFS_CONFIG);
		chk("reset config", rdv, {13'h0000, RST_CONFIG});
		$display("reset test done");
		// erase: plain, zero count, media fault
		for (int i = 0; i < 3; i++) begin
			lba = i[0];
			load(lba, 1'b0, i == 2, 8'h00);
			if (i == 1) begin
				tf[0] = 8'h00;
				wr(OFS_SEC_CNT, 16'h0000);
			end
			cmd(CMD_ERASE, 1'b1);
			// lands while busy still stands, so it must be ignored
			wr(OFS_SEC_NUM, {8'h00, ~tf[1]});
			fin((i == 2) ? 8'h71 : 8'h50, 1'b1);
			chk("op", {14'h0, lastReq.op}, {14'h0, MED_ERASE});
			chk("addr lo", lastReq.addr[15:0], {tf[2], tf[1]});
			chk("addr hi", {4'h0, lastReq.addr[27:16]}, {4'h0, tf[4][3:0], tf[3]});
			chk("count", {7'h0, lastReq.count}, expCnt(tf[0]));
			chk("lba", {15'h0, lastReq.lbaMode}, {15'h0, lba});
			rd(OFS_SEC_NUM);
			chk("sec num held", rdv, {8'h00, tf[1]});
		end
		$display("erase test done");
		for (int k = 1; k < 6; k++) begin
			load(1'b0, 1'b0, 1'b0, 8'(k));
			cmd(CMD_DIAG, 1'b1);
			fin(8'h50, 1'b1);
			rd(OFS_ERROR);
			chk("diag code", rdv, 16'(k));
		end
		// dual-drive mode runs regardless of drive bit; slave failure marked
		wr(OFS_CONFIG, 16'h0005);
		slaveDiagFail <= 1'b1;
		load(1'b0, 1'b1, 1'b0, DIAG_FORMATTER);
		cmd(CMD_DIAG, 1'b1);
		fin(8'h50, 1'b1);
		rd(OFS_ERROR);
		chk("slave code", rdv, 16'h0082);
		slaveDiagFail <= 1'b0;
		wr(OFS_CONFIG, 16'h0004);
		load(1'b0, 1'b1, 1'b0, DIAG_OK);
		n = reqCount;
		cmd(CMD_DIAG, 1'b0);
		repeat (20) @(posedge clk);
		chk("unselected", 16'(reqCount - n), 16'h0000);
		$display("diag test done");
		load(1'b0, 1'b0, 1'b0, 8'h00);
		for (int r = 0; r < 5; r++) begin
			rd(4'(r));
			chk("task file", rdv, {8'h00, tf[r]});
		end
		cmd(CMD_FLUSH, 1'b1);
		fin(8'h50, 1'b1);
		wr(OFS_DEV_CTL, 16'h0002);
		rd(OFS_DEV_CTL);
		chk("irq mask", rdv, 16'h0002);
		cmd(CMD_FLUSH, 1'b1);
		fin(8'h50, 1'b0);
		wr(OFS_DEV_CTL, 16'h0000);
		wr(OFS_CONFIG, 16'h0000);
		rd(OFS_CONFIG);
		chk("config", rdv, 16'h0000);
		cmd(CMD_FLUSH, 1'b1);
		fin(8'h51, 1'b1);
		rd(OFS_ERROR);
		chk("abort", rdv, 16'h0004);
		// a code outside this block's set is refused the same way
		cmd(8'hA5, 1'b1);
		fin(8'h51, 1'b1);
		rd(OFS_ERROR);
		chk("unknown code", rdv, 16'h0004);
		wr(OFS_CONFIG, 16'h0004);
		$display("flush test done");
		// one format per addressing mode only: the host is advised against it
		for (int m = 0; m < 2; m++) begin
			lba = (m == 0);
			load(lba, 1'b0, 1'b0, 8'h00);
			if (lba) begin
				tf[0] = 8'h00;
				wr(OFS_SEC_CNT, 16'h0000);
			end
			cmd(CMD_FORMAT, 1'b1);
			rdv = 16'h0000;
			for (int j = 0; j < 30 && !rdv[3]; j++) rd(OFS_CMD_STAT);
			chk("drq", {14'h0, rdv[7], rdv[3]}, 16'h0001);
			for (int j = 0; j < 255; j++) wr(OFS_DATA, 16'($urandom));
			// one word short of a sector the request must still stand
			rd(OFS_CMD_STAT);
			chk("drq last word", {14'h0, rdv[7], rdv[3]}, 16'h0001);
			wr(OFS_DATA, 16'($urandom));
			fin(8'h50, 1'b1);
			rd(OFS_DATA);
			chk("data discarded", rdv, 16'h0000);
			chk("fmt op", {14'h0, lastReq.op}, {14'h0, MED_FORMAT});
			chk("fmt fill", {8'h00, lastReq.pattern}, 16'h00FF);
			chk("fmt count", {7'h0, lastReq.count}, lba ? expCnt(tf[0]) : 16'h0000);
			chk("fmt addr", lastReq.addr[23:8], {tf[3], tf[2]});
			chk("fmt head", {12'h000, lastReq.addr[27:24]}, {12'h000, tf[4][3:0]});
			chk("fmt lba", {15'h0, lastReq.lbaMode}, {15'h0, lba});
		end
		$display("format test done");
		summarize();
	end
endmodule
